// ===== src/tcmp_timer16.sv
// 16-bit timer with two output compare channels, clear-on-match and AXI4-Lite registers
//
// Summary of operation
// [RULE_01] counter write blocks matches next timer tick
// [RULE_02] written TOP in PWM ignored, counts to max
// [RULE_03] software avoids writing BOTTOM while counting down
// [RULE_04] output state survives waveform mode changes
// [RULE_05] action bits take effect at next match
// [RULE_06] reset clears both output states to zero
// [RULE_07] route bit plus nonzero action overrides port
// [RULE_08] port direction still gates pin drive
// [RULE_09] action zero leaves output state unchanged
// [RULE_10] action bits never touch capture logic
// [RULE_11] force strobe applies action at once, non-PWM
// [RULE_12] only waveform select shapes counting
// [RULE_13] PWM: polarity; otherwise set, clear, toggle (toggle action still flips on each match in PWM modes)
// [RULE_14] normal mode counts up, wraps max to zero
// [RULE_15] normal mode overflow flag set on wrap
// [RULE_16] normal mode accepts counter writes anytime
// [RULE_17] clear-on-match: TOP from compare A or capture
// [RULE_18] TOP hit sets compare A or capture flag
// [RULE_19] unbuffered TOP; missed TOP waits for wrap
// [RULE_20] toggle action halves match rate on pin
// [RULE_21] clear-on-match overflow flag on max wrap
// [RULE_22] match sets flag; ack or write-one clears
// [RULE_23] forced compare sets no flag, keeps counter
// [RULE_24] both channels identical, only A gives TOP
//
// Chosen here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/10ps

module tcmp_timer16 (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire tcmp_pkg::tcmp_axi_req_s axiReq,
  output tcmp_pkg::tcmp_axi_rsp_s axiRsp,
  // prescaled timer clock enable and interrupt acknowledges
  input wire logic timerTick,
  input wire logic [3:0] flagAck,
  // compare output pins
  output logic [1:0] pinOut,
  output logic [1:0] pinOe
);

  //////////////////////////////////////////////////////////////////////////////

  tcmp_pkg::tcmp_state_s st_ff;
  tcmp_pkg::tcmp_state_s nxt_st;

  logic wrEn;
  logic rdEn;
  logic [31:0] wrWord;
  logic cntWr;
  logic [1:0] forceHit;
  logic [3:0] flagClr;
  logic [3:0] flagSet;
  logic pwm;
  logic [15:0] topVal;
  logic topHit;
  logic wrapHit;
  logic [1:0] match;

  //////////////////////////////////////////////////////////////////////////////

  // counter limit for each waveform select; channel A alone may supply it
  function automatic logic [15:0] topOf(input logic [3:0] wave, input logic [15:0] cmpA,
                                        input logic [15:0] capt);
    case (wave)
      4'h1, 4'h5: topOf = tcmp_pkg::TOP_8BIT;
      4'h2, 4'h6: topOf = tcmp_pkg::TOP_9BIT;
      4'h3, 4'h7: topOf = tcmp_pkg::TOP_10BIT;
      4'h4, 4'h9, 4'hB, 4'hF: topOf = cmpA; // see [RULE_17] see [RULE_24]
      4'h8, 4'hA, 4'hC, 4'hE: topOf = capt; // see [RULE_17]
      default: topOf = tcmp_pkg::CNT_MAX;
    endcase
  endfunction

  function automatic logic topFromCapt(input logic [3:0] wave);
    case (wave)
      4'h8, 4'hA, 4'hC, 4'hE: topFromCapt = 1'b1;
      default: topFromCapt = 1'b0;
    endcase
  endfunction

  function automatic logic isPwm(input logic [3:0] wave);
    case (wave)
      tcmp_pkg::MODE_NORMAL, tcmp_pkg::MODE_CLR_A, tcmp_pkg::MODE_CLR_CAPT,
      tcmp_pkg::MODE_RSVD: isPwm = 1'b0;
      default: isPwm = 1'b1;
    endcase
  endfunction

  // output state after a match or TOP event under the given action
  function automatic logic nextOc(input logic oc, input logic [1:0] act, input logic pwmMode,
                                  input logic hit, input logic atTop);
    logic res;
    res = oc;
    if (pwmMode) begin
      // clear and set pick the polarity, level restored when the count restarts; toggle flips on each match
      if (atTop && act == tcmp_pkg::ACT_CLEAR) begin
        res = 1'b0; // see [RULE_13]
      end else if (atTop && act == tcmp_pkg::ACT_SET) begin
        res = 1'b1; // see [RULE_13]
      end
      if (hit) begin
        case (act)
          tcmp_pkg::ACT_TOGGLE: res = ~oc;
          tcmp_pkg::ACT_CLEAR: res = 1'b1;
          tcmp_pkg::ACT_SET: res = 1'b0;
          default: res = res; // see [RULE_09]
        endcase
      end
    end else if (hit) begin
      case (act)
        tcmp_pkg::ACT_TOGGLE: res = ~oc; // see [RULE_13] see [RULE_20]
        tcmp_pkg::ACT_CLEAR: res = 1'b0;
        tcmp_pkg::ACT_SET: res = 1'b1;
        default: res = oc; // see [RULE_09]
      endcase
    end
    nextOc = res;
  endfunction

  function automatic logic [31:0] regRead(input tcmp_pkg::tcmp_state_s s,
                                          input logic [tcmp_pkg::ADDR_W-1:0] addr);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (addr)
      tcmp_pkg::OFS_CTRL: begin
        v[tcmp_pkg::WAVE_LSB +: 4] = s.wave;
        v[tcmp_pkg::ACT_A_LSB +: 2] = s.act[0];
        v[tcmp_pkg::ACT_B_LSB +: 2] = s.act[1];
      end
      tcmp_pkg::OFS_COUNT: v[15:0] = s.cnt;
      tcmp_pkg::OFS_CMP_A: v[15:0] = s.cmp[0];
      tcmp_pkg::OFS_CMP_B: v[15:0] = s.cmp[1];
      tcmp_pkg::OFS_CAPT: v[15:0] = s.capt;
      tcmp_pkg::OFS_FLAGS: v[3:0] = s.flags;
      tcmp_pkg::OFS_ROUTE: v[1:0] = s.route;
      tcmp_pkg::OFS_PORT: begin
        v[tcmp_pkg::PORT_DAT_LSB +: 2] = s.portDat;
        v[tcmp_pkg::PORT_DIR_LSB +: 2] = s.portDir;
      end
      tcmp_pkg::OFS_STATUS: begin
        v[tcmp_pkg::STAT_OC_LSB +: 2] = s.oc;
        v[tcmp_pkg::STAT_BLK_BIT] = s.blk;
      end
      default: v = 32'h0000_0000;
    endcase
    regRead = v;
  endfunction

  function automatic logic mapped(input logic [tcmp_pkg::ADDR_W-1:0] addr);
    case (addr)
      tcmp_pkg::OFS_CTRL, tcmp_pkg::OFS_COUNT, tcmp_pkg::OFS_CMP_A, tcmp_pkg::OFS_CMP_B,
      tcmp_pkg::OFS_CAPT, tcmp_pkg::OFS_FLAGS, tcmp_pkg::OFS_FORCE, tcmp_pkg::OFS_ROUTE,
      tcmp_pkg::OFS_PORT, tcmp_pkg::OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    nxt_st = st_ff;
    cntWr = 1'b0;
    forceHit = 2'b00;
    flagClr = flagAck; // see [RULE_22]
    flagSet = 4'h0;
    match = 2'b00;
    pwm = isPwm(st_ff.wave);
    topVal = topOf(st_ff.wave, st_ff.cmp[0], st_ff.capt);

    // bus: address and data are taken independently, in either order
    if (st_ff.rsp.bvalid && axiReq.bready) begin
      nxt_st.rsp.bvalid = 1'b0;
    end
    if (axiReq.awvalid && st_ff.rsp.awready) begin
      nxt_st.awHeld = 1'b1;
      nxt_st.awAddr = axiReq.awaddr;
    end
    if (axiReq.wvalid && st_ff.rsp.wready) begin
      nxt_st.wHeld = 1'b1;
      nxt_st.wData = axiReq.wdata;
      nxt_st.wStrb = axiReq.wstrb;
    end

    wrEn = st_ff.awHeld && st_ff.wHeld && !st_ff.rsp.bvalid;
    wrWord = regRead(st_ff, st_ff.awAddr);
    for (int b = 0; b < 4; b++) begin
      if (st_ff.wStrb[b]) begin
        wrWord[8*b +: 8] = st_ff.wData[8*b +: 8];
      end
    end

    if (wrEn) begin
      nxt_st.awHeld = 1'b0;
      nxt_st.wHeld = 1'b0;
      nxt_st.rsp.bvalid = 1'b1;
      nxt_st.rsp.bresp = mapped(st_ff.awAddr) ? tcmp_pkg::RESP_OKAY : tcmp_pkg::RESP_SLVERR;
      case (st_ff.awAddr)
        tcmp_pkg::OFS_CTRL: begin
          // mode change leaves the output state alone
          nxt_st.wave = wrWord[tcmp_pkg::WAVE_LSB +: 4]; // see [RULE_04] see [RULE_12]
          nxt_st.act[0] = wrWord[tcmp_pkg::ACT_A_LSB +: 2]; // see [RULE_05]
          nxt_st.act[1] = wrWord[tcmp_pkg::ACT_B_LSB +: 2];
        end
        tcmp_pkg::OFS_COUNT: cntWr = 1'b1; // see [RULE_16]
        tcmp_pkg::OFS_CMP_A: nxt_st.cmp[0] = wrWord[15:0]; // see [RULE_19]
        tcmp_pkg::OFS_CMP_B: nxt_st.cmp[1] = wrWord[15:0];
        tcmp_pkg::OFS_CAPT: nxt_st.capt = wrWord[15:0]; // see [RULE_19]
        tcmp_pkg::OFS_FLAGS: flagClr = flagAck | (st_ff.wData[3:0] & {4{st_ff.wStrb[0]}});
        tcmp_pkg::OFS_FORCE: begin
          // strobes are ignored in PWM modes and read back as zero
          forceHit = (st_ff.wData[1:0] & {2{st_ff.wStrb[0]}}) & {2{!pwm}}; // see [RULE_11]
        end
        tcmp_pkg::OFS_ROUTE: nxt_st.route = wrWord[1:0];
        tcmp_pkg::OFS_PORT: begin
          nxt_st.portDat = wrWord[tcmp_pkg::PORT_DAT_LSB +: 2];
          nxt_st.portDir = wrWord[tcmp_pkg::PORT_DIR_LSB +: 2];
        end
        default: nxt_st.rsp.bresp = nxt_st.rsp.bresp;
      endcase
    end
    nxt_st.rsp.awready = !nxt_st.awHeld && !nxt_st.rsp.bvalid;
    nxt_st.rsp.wready = !nxt_st.wHeld && !nxt_st.rsp.bvalid;

    // read channel: one outstanding read, data frozen until taken
    rdEn = axiReq.arvalid && st_ff.rsp.arready;
    if (st_ff.rsp.rvalid && axiReq.rready) begin
      nxt_st.rsp.rvalid = 1'b0;
    end
    if (rdEn) begin
      nxt_st.rsp.rvalid = 1'b1;
      nxt_st.rsp.rdata = regRead(st_ff, axiReq.araddr);
      nxt_st.rsp.rresp = mapped(axiReq.araddr) ? tcmp_pkg::RESP_OKAY : tcmp_pkg::RESP_SLVERR;
    end
    nxt_st.rsp.arready = !nxt_st.rsp.rvalid;

    // matches are only evaluated on a timer tick and not right after a count write
    topHit = timerTick && !st_ff.blk && st_ff.wave != tcmp_pkg::MODE_NORMAL &&
             st_ff.cnt == topVal; // see [RULE_01] see [RULE_02]
    // a count write at the tick edge wins, so no wrap happens then; only a PWM TOP hit can still set overflow
    wrapHit = timerTick && !cntWr && st_ff.cnt == tcmp_pkg::CNT_MAX; // see [RULE_14]
    for (int c = 0; c < 2; c++) begin
      // identical per channel; the capture side never reads the action bits
      match[c] = timerTick && !st_ff.blk && st_ff.cnt == st_ff.cmp[c]; // see [RULE_01] see [RULE_24]
      nxt_st.oc[c] = nextOc(st_ff.oc[c], st_ff.act[c], pwm, match[c] || forceHit[c],
                            pwm && topHit); // see [RULE_10] see [RULE_23]
    end

    // counter: a write overrides the tick and arms one tick of blocking
    if (cntWr) begin
      nxt_st.cnt = wrWord[15:0];
      nxt_st.blk = 1'b1; // see [RULE_01]
    end else if (timerTick) begin
      nxt_st.blk = 1'b0;
      if (topHit) begin
        nxt_st.cnt = tcmp_pkg::CNT_BOTTOM; // see [RULE_17]
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h0001; // see [RULE_14] see [RULE_19]
      end
    end

    flagSet[tcmp_pkg::FLG_OVF] = wrapHit || (pwm && topHit); // see [RULE_15] see [RULE_21]
    flagSet[tcmp_pkg::FLG_CMP_A] = match[0]; // see [RULE_18] see [RULE_22]
    flagSet[tcmp_pkg::FLG_CMP_B] = match[1]; // see [RULE_22]
    flagSet[tcmp_pkg::FLG_CAPT] = topHit && topFromCapt(st_ff.wave); // see [RULE_18]
    // a set in the clearing cycle wins so no event is lost
    nxt_st.flags = (st_ff.flags & ~flagClr) | flagSet; // see [RULE_22]

    // pins follow the state just computed so the flop output is aligned with it
    for (int c = 0; c < 2; c++) begin
      if (nxt_st.act[c] != tcmp_pkg::ACT_NONE && nxt_st.route[c]) begin
        nxt_st.pinOut[c] = nxt_st.oc[c]; // see [RULE_07]
      end else begin
        nxt_st.pinOut[c] = nxt_st.portDat[c];
      end
    end
    nxt_st.pinOe = nxt_st.portDir; // see [RULE_08]
  end

  //////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_ff <= '0; // see [RULE_06]
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign axiRsp = st_ff.rsp;
  assign pinOut = st_ff.pinOut;
  assign pinOe = st_ff.pinOe;

endmodule

// ===== src/tcmp_pkg.sv
// package: register map, field layout, mode codes and bus carriers of the 16-bit timer compare block
package tcmp_pkg;

  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_CMP_A = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CMP_B = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_CAPT = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_FLAGS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FORCE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_ROUTE = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_PORT = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;

  // control register fields
  localparam int WAVE_LSB = 0;
  localparam int ACT_A_LSB = 4;
  localparam int ACT_B_LSB = 6;
  // port register fields
  localparam int PORT_DAT_LSB = 0;
  localparam int PORT_DIR_LSB = 2;
  // status register fields
  localparam int STAT_OC_LSB = 0;
  localparam int STAT_BLK_BIT = 2;

  // flag bits
  localparam int FLG_OVF = 0;
  localparam int FLG_CMP_A = 1;
  localparam int FLG_CMP_B = 2;
  localparam int FLG_CAPT = 3;

  // waveform select codes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CLR_A = 4'h4;
  localparam logic [3:0] MODE_CLR_CAPT = 4'hC;
  localparam logic [3:0] MODE_RSVD = 4'hD;

  // fixed counter limits
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] TOP_8BIT = 16'h00FF;
  localparam logic [15:0] TOP_9BIT = 16'h01FF;
  localparam logic [15:0] TOP_10BIT = 16'h03FF;

  // compare output actions
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;

  // bus responses and reset values
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic OC_RESET = 1'b0;

  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } tcmp_axi_req_s;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcmp_axi_rsp_s;

  typedef struct packed {
    tcmp_axi_rsp_s rsp;
    logic awHeld;
    logic [ADDR_W-1:0] awAddr;
    logic wHeld;
    logic [31:0] wData;
    logic [3:0] wStrb;
    logic [3:0] wave;
    logic [1:0][1:0] act;
    logic [15:0] cnt;
    logic [1:0][15:0] cmp;
    logic [15:0] capt;
    logic [3:0] flags;
    logic [1:0] route;
    logic [1:0] portDat;
    logic [1:0] portDir;
    logic [1:0] oc;
    logic blk;
    logic [1:0] pinOut;
    logic [1:0] pinOe;
  } tcmp_state_s;

endpackage

// ===== testbench/tcmp_timer16_chk.sv
// port-level assertions for the 16-bit timer compare block
`timescale 1ns/10ps
module tcmp_timer16_chk (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register bus
  input wire tcmp_pkg::tcmp_axi_req_s axiReq,
  input wire tcmp_pkg::tcmp_axi_rsp_s axiRsp,
  // timer inputs
  input wire logic timerTick,
  input wire logic [3:0] flagAck,
  // compare output pins
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  AST_RST_CLEAR:
    assert property ($fell(sys_rst) |-> pinOut == 2'h0 && pinOe == 2'h0)
    else $error("pins not cleared by reset");
  // a pin moves only the edge after a tick or the edge at which a write answer rises
  AST_PIN_CAUSE:
    assert property ($changed(pinOut) |-> $past(timerTick) || $rose(axiRsp.bvalid))
    else $error("pin level changed without tick or write");
  AST_DIR_CAUSE:
    assert property ($changed(pinOe) |-> $rose(axiRsp.bvalid))
    else $error("pin direction changed without a write");
  AST_RST_READY:
    assert property ($fell(sys_rst) |=> axiRsp.awready && axiRsp.arready)
    else $error("bus not ready after reset");
  AST_R_LAT:
    assert property (axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid)
    else $error("read answer late");
  AST_B_LAT:
    assert property (axiReq.awvalid && axiRsp.awready && axiReq.wvalid && axiRsp.wready
      |=> ##1 axiRsp.bvalid)
    else $error("write answer late");
  AST_AW_REFUSE:
    assert property (axiRsp.bvalid |-> !axiRsp.awready && !axiRsp.wready)
    else $error("write taken while answer pending");
  AST_AR_REFUSE:
    assert property (axiRsp.rvalid |-> !axiRsp.arready)
    else $error("read taken while answer pending");
endmodule

bind tcmp_timer16 tcmp_timer16_chk chk_u (.clk(clk), .sys_rst(sys_rst), .axiReq(axiReq),
  .axiRsp(axiRsp), .timerTick(timerTick), .flagAck(flagAck), .pinOut(pinOut), .pinOe(pinOe));

// ===== testbench/tcmp_pin_pad.sv
// port pin pads with pull-downs on the far side of the compare outputs
`timescale 1ns/10ps
module tcmp_pin_pad (
  // block side
  input wire logic [1:0] pinOut,
  input wire logic [1:0] pinOe,
  // pad side
  output logic [1:0] padLevel
);
  // an undriven pad falls to the pull-down, never keeps the last level
  assign padLevel = pinOe & pinOut;
endmodule

// ===== testbench/tcmp_timer16_tb.sv
// self-checking bench for the 16-bit timer compare block
`timescale 1ns/10ps
module tcmp_timer16_tb;
  logic clk, rst, timerTick;
  logic [3:0] flagAck;
  logic [1:0] pinOut, pinOe, pad, lastResp;
  logic [31:0] rdat;
  logic [31:0] seed = 32'h0000_0044;
  tcmp_pkg::tcmp_axi_req_s req;
  tcmp_pkg::tcmp_axi_rsp_s rsp;
  int badCount, checks, cyc;
  // bench model state
  int mode, cnt, capt, flg, route, port, blk;
  int cmp[2], act[2], oc[2];

  tcmp_timer16 dut_u (.clk(clk), .sys_rst(rst), .axiReq(req), .axiRsp(rsp),
    .timerTick(timerTick), .flagAck(flagAck), .pinOut(pinOut), .pinOe(pinOe));
  tcmp_pin_pad pad_u (.pinOut(pinOut), .pinOe(pinOe), .padLevel(pad));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      badCount++;
      closeOut();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int doAct(int a, int o);
    return (a == 1) ? !o : (a == 2) ? 0 : (a == 3) ? 1 : o;
  endfunction
  function automatic void mw(logic [7:0] a, logic [31:0] d);
    case (a)
      8'h00: begin
        mode = d[3:0];
        act[0] = d[5:4];
        act[1] = d[7:6];
      end
      8'h04: begin
        cnt = d[15:0];
        blk = 1;
      end
      8'h08: cmp[0] = d[15:0];
      8'h0C: cmp[1] = d[15:0];
      8'h10: capt = d[15:0];
      8'h14: flg &= ~d[3:0];
      8'h18: for (int c = 0; c < 2; c++) if (d[c] && !pwmM(mode)) oc[c] = doAct(act[c], oc[c]);
      8'h1C: route = d[1:0];
      8'h20: port = d[3:0];
      default: ;
    endcase
  endfunction
  function automatic int pwmM(int m);
    return !(m == 0 || m == 4 || m == 12 || m == 13);
  endfunction
  function automatic void mclr();
    mode = 0;
    cnt = 0;
    capt = 0;
    flg = 0;
    route = 0;
    port = 0;
    blk = 0;
    for (int c = 0; c < 2; c++) begin
      cmp[c] = 0;
      act[c] = 0;
      oc[c] = 0;
    end
  endfunction
  function automatic void step();
    int top, hit, pw;
    pw = pwmM(mode);
    case (mode)
      1, 5: top = 255;
      2, 6: top = 511;
      3, 7: top = 1023;
      4, 9, 11, 15: top = cmp[0];
      8, 10, 12, 14: top = capt;
      default: top = 65535;
    endcase
    // the TOP match is a compare match too, so a count write blocks it
    hit = !blk && mode != 0 && cnt == top;
    for (int c = 0; c < 2; c++) begin
      if (pw && hit && act[c] >= 2) oc[c] = act[c] - 2;
      if (!blk && cnt == cmp[c]) begin
        flg |= 2 << c;
        if (pw) oc[c] = (act[c] == 1) ? !oc[c] : (act[c] == 2) ? 1 : (act[c] == 3) ? 0 : oc[c];
        else oc[c] = doAct(act[c], oc[c]);
      end
    end
    if (hit && (mode == 8 || mode == 10 || mode == 12 || mode == 14)) flg |= 8;
    if (cnt == 65535 || (pw && hit)) flg |= 1;
    cnt = hit ? 0 : (cnt + 1) % 65536;
    blk = 0;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      badCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    req.awvalid <= 1'h1;
    req.awaddr <= a;
    req.wvalid <= 1'h1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'h1;
    fork
      begin
        do @(posedge clk); while (!rsp.awready);
        req.awvalid <= 1'h0;
      end
      begin
        do @(posedge clk); while (!rsp.wready);
        req.wvalid <= 1'h0;
      end
    join
    do @(posedge clk); while (!rsp.bvalid);
    lastResp = rsp.bresp;
    req.bready <= 1'h0;
    @(posedge clk);
    mw(a, d);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    req.arvalid <= 1'h1;
    req.araddr <= a;
    req.rready <= 1'h1;
    do @(posedge clk); while (!rsp.arready);
    req.arvalid <= 1'h0;
    do @(posedge clk); while (!rsp.rvalid);
    d = rsp.rdata;
    lastResp = rsp.rresp;
    req.rready <= 1'h0;
    @(posedge clk);
  endtask
  task automatic cr(string nm, logic [7:0] a, logic [31:0] e);
    rd(a, rdat);
    chk(nm, rdat, e);
  endtask
  // pins change at the same edge as the state; they are looked at after the reads
  task automatic vall();
    logic [1:0] ep;
    for (int c = 0; c < 2; c++) ep[c] = (act[c] != 0 && route[c]) ? oc[c] : port[c];
    cr("count", 8'h04, cnt);
    cr("flags", 8'h14, flg);
    cr("status", 8'h24, {blk[0], oc[1][0], oc[0][0]});
    chk("pin", pinOut, ep);
    chk("dir", pinOe, port[3:2]);
    chk("pad", pad, ep & port[3:2]);
  endtask
  task automatic tick(int n);
    repeat (n) begin
      step();
      timerTick <= 1'h1;
      @(posedge clk);
    end
    timerTick <= 1'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic closeOut();
    $display("checks %0d mismatches %0d", checks, badCount);
    if (badCount == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'h1;
    req = '0;
    timerTick = 1'h0;
    flagAck = 4'h0;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    vall();
    rd(8'h40, rdat);
    chk("resp", lastResp, 2'h2);
    chk("unmapped", rdat, 32'h0000_0000);
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      wr(8'h04, i ? rnd() & 32'h0000_FFFF : 32'h0000_FFFD);
      tick(3);
      vall();
    end
    flagAck <= 4'h1;
    @(posedge clk);
    flagAck <= 4'h0;
    flg &= 14;
    vall();
    $display("test normal done");
    // a count write blocks the next tick's match even after an idle gap
    wr(8'h08, 32'h0000_0005);
    wr(8'h04, 32'h0000_0005);
    repeat (4) @(posedge clk);
    tick(1);
    vall();
    wr(8'h04, 32'h0000_0004);
    tick(2);
    vall();
    wr(8'h14, 32'h0000_000F);
    vall();
    $display("test blocking done");
    wr(8'h20, 32'h0000_000C);
    wr(8'h1C, 32'h0000_0003);
    for (int a = 0; a < 4; a++) begin
      wr(8'h00, a << 4 | (3 - a) << 6);
      wr(8'h18, 32'h0000_0003);
      chk("bresp", lastResp, 2'h0);
      vall();
    end
    $display("test force done");
    // up-counting modes only, so no count write meets a falling count
    for (int m = 0; m < 2; m++) begin
      wr(8'h00, m ? 32'h0000_001C : 32'h0000_0014);
      vall();
      wr(8'h10, 32'h0000_0003);
      wr(8'h08, 32'h0000_0003);
      wr(8'h04, 32'h0000_0000);
      repeat (8) begin
        tick(1);
        chk("toggle", pinOut[0], oc[0]);
      end
      vall();
      wr(8'h04, 32'h0000_FFFE);
      tick(6);
      vall();
    end
    $display("test clear on match done");
    // single-slope PWM with TOP from compare A; force strobes are ignored here
    wr(8'h00, 32'h0000_008F);
    vall();
    wr(8'h08, 32'h0000_0004);
    wr(8'h0C, 32'h0000_0002);
    wr(8'h18, 32'h0000_0003);
    vall();
    wr(8'h04, 32'h0000_0004);
    tick(3);
    vall();
    wr(8'h04, 32'h0000_FFFE);
    tick(7);
    vall();
    $display("test pwm done");
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    mclr();
    @(posedge clk);
    vall();
    $display("test mid reset done");
    closeOut();
  end
endmodule
